// ==== ffs_top.sv ====
// Operation
// - Busy flag at bit 3 of command status mirrors controller activity.
// - Busy reads 1 while a command or the reset sequence runs (complete flag 0), else 0.
// - Reserved status bits read zero and ignore writes.
// - Completion status bits set on errors during commands or reset sequence.
// - After reset, completion status shows any reset-sequence double fault.
// - Double-fault flag, error status bit 1, set on double-bit read fault.
// - Read colliding with a running command sets both fault flags.
// - Writing 1 clears double-fault flag; writing 0 leaves it.
// - A genuine parity fault sets single or double flag, never both.
// - Fault flags are stored one cycle after the detecting read.
// - With ignore bit clear, single-bit fault sets flag at bit 0.
// - Single-bit faults are corrected in returned data, whether or not the ignore bit lets the flag set.
// - Writing 1 clears single-fault flag; writing 0 has no effect.
// - Single-fault interrupt enable requests interrupt while flag is set.
// - Writing 1 to complete flag launches command; low until completion.
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "ffs_map.svh"

module ffs_top
  import ffs_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic init_done,
  input wire logic init_dfault,
  input wire ffs_cmd_done_s cmd_done,
  output logic cmd_launch,
  input wire ffs_rd_s rd,
  output ffs_byte_t rd_data_out,
  output logic rd_data_valid,
  output logic irq
);

  if (ADDR_W < 16) begin : g_addr_check
    $error("ADDR_W must be at least 16 to reach the register indices");
  end

  // Held as a typed constant so single bits can be selected from it
  localparam logic [7:0] RST_CFG = `FFS_RST_CFG;

  ffs_state_s s_reg;
  ffs_state_s s_next;

  logic set_sf;
  logic set_df;
  ffs_byte_t data_fixed;
  logic ctrl_busy_flag;
  logic wr_go;
  logic wen;
  logic wr_hit;
  logic ar_take;
  logic ar_hit;
  logic [13:0] ar_idx;
  logic ar_hi_ok;
  logic aw_hi_ok;
  logic wr_cstat;
  logic wr_estat;
  logic wr_cfg;
  logic wr_istat;
  logic wr_imask;
  logic clr_sf;
  logic clr_df;
  logic cmd_go;
  logic [2:0] irq_ev;
  logic [31:0] rd_word;

  ffs_fault_sort ffs_fault_sort_i (
    .rd(rd),
    .ignore_single_fault(s_reg.ign_sf),
    .set_sf(set_sf),
    .set_df(set_df),
    .data_fixed(data_fixed)
  );

  // Busy is the controller state itself, so it can never disagree with the complete flag
  assign ctrl_busy_flag = (s_reg.cmd != CS_IDLE);

  if (ADDR_W > 16) begin : g_hi
    assign aw_hi_ok = (s_axi_awaddr[ADDR_W-1:16] == '0);
    assign ar_hi_ok = (s_axi_araddr[ADDR_W-1:16] == '0);
  end else begin : g_nohi
    assign aw_hi_ok = 1'b1;
    assign ar_hi_ok = 1'b1;
  end

  assign ar_idx = s_axi_araddr[15:2];
  assign ar_take = s_axi_arvalid & s_reg.arready;
  assign ar_hit = ar_hi_ok & ((ar_idx == `FFS_IDX_CFG) | (ar_idx == `FFS_IDX_CSTAT)
                  | (ar_idx == `FFS_IDX_ESTAT) | (ar_idx == `FFS_IDX_IRQ_STAT)
                  | (ar_idx == `FFS_IDX_IRQ_MASK));

  assign wr_go = s_reg.aw_held & s_reg.w_held & ~s_reg.bvalid;
  assign wr_hit = s_reg.aw_hit_ok & ((s_reg.aw_idx == `FFS_IDX_CFG)
                  | (s_reg.aw_idx == `FFS_IDX_CSTAT) | (s_reg.aw_idx == `FFS_IDX_ESTAT)
                  | (s_reg.aw_idx == `FFS_IDX_IRQ_STAT) | (s_reg.aw_idx == `FFS_IDX_IRQ_MASK));
  // Registers are 8 bits wide, so only byte lane 0 carries a write
  assign wen = wr_go & wr_hit & s_reg.wlane;
  assign wr_cfg = wen & (s_reg.aw_idx == `FFS_IDX_CFG);
  assign wr_cstat = wen & (s_reg.aw_idx == `FFS_IDX_CSTAT);
  assign wr_estat = wen & (s_reg.aw_idx == `FFS_IDX_ESTAT);
  assign wr_istat = wen & (s_reg.aw_idx == `FFS_IDX_IRQ_STAT);
  assign wr_imask = wen & (s_reg.aw_idx == `FFS_IDX_IRQ_MASK);
  assign clr_sf = wr_estat & s_reg.wdata[`FFS_BIT_SF];
  assign clr_df = wr_estat & s_reg.wdata[`FFS_BIT_DF];
  assign cmd_go = wr_cstat & s_reg.wdata[`FFS_BIT_CPL] & (s_reg.cmd == CS_IDLE);

  assign irq_ev[`FFS_IRQ_SF] = set_sf;
  assign irq_ev[`FFS_IRQ_DF] = set_df;
  assign irq_ev[`FFS_IRQ_CMD] = (s_reg.cmd == CS_RUN) & cmd_done.done;

  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (ar_idx)
      `FFS_IDX_CFG: begin
        rd_word[`FFS_BIT_SFIE] = s_reg.sfie;
        rd_word[`FFS_BIT_IGN_SF] = s_reg.ign_sf;
      end
      `FFS_IDX_CSTAT: begin
        // Bit 2 and the unimplemented bits stay zero
        rd_word[`FFS_BIT_CPL] = s_reg.cpl_flag;
        rd_word[`FFS_BIT_BUSY] = ctrl_busy_flag;
        rd_word[`FFS_CPL_MSB:0] = s_reg.cpl_stat;
      end
      `FFS_IDX_ESTAT: begin
        rd_word[`FFS_BIT_DF] = s_reg.df;
        rd_word[`FFS_BIT_SF] = s_reg.sf;
      end
      `FFS_IDX_IRQ_STAT: rd_word[`FFS_IRQ_W-1:0] = s_reg.irq_stat;
      `FFS_IDX_IRQ_MASK: rd_word[`FFS_IRQ_W-1:0] = s_reg.irq_mask;
      default: rd_word = 32'h0000_0000;
    endcase
    if (!ar_hi_ok) begin
      rd_word = 32'h0000_0000;
    end
  end

  always_comb begin
    s_next = s_reg;
    s_next.launch = 1'b0;
    s_next.rd_valid = rd.strobe;
    s_next.rd_data = rd.strobe ? data_fixed : s_reg.rd_data;

    unique case (s_reg.cmd)
      CS_INIT: begin
        if (init_done) begin
          s_next.cmd = CS_IDLE;
          s_next.cpl_flag = 1'b1;
          if (init_dfault) begin
            s_next.cpl_stat = s_reg.cpl_stat | `FFS_CPL_DFAULT;
          end
        end
      end
      CS_IDLE: begin
        if (cmd_go) begin
          s_next.cmd = CS_RUN;
          s_next.cpl_flag = 1'b0;
          s_next.cpl_stat = 2'h0;
          s_next.launch = 1'b1;
        end
      end
      CS_RUN: begin
        if (cmd_done.done) begin
          s_next.cmd = CS_IDLE;
          s_next.cpl_flag = 1'b1;
          s_next.cpl_stat = cmd_done.err;
        end
      end
    endcase

    // Hardware set beats a software clear in the same cycle
    s_next.sf = (s_reg.sf & ~clr_sf) | set_sf;
    s_next.df = (s_reg.df & ~clr_df) | set_df;

    if (wr_cfg) begin
      s_next.sfie = s_reg.wdata[`FFS_BIT_SFIE];
      s_next.ign_sf = s_reg.wdata[`FFS_BIT_IGN_SF];
    end
    if (wr_imask) begin
      s_next.irq_mask = s_reg.wdata[`FFS_IRQ_W-1:0];
    end
    s_next.irq_stat = (s_reg.irq_stat & ~(wr_istat ? s_reg.wdata[`FFS_IRQ_W-1:0] : 3'h0))
                      | irq_ev;
    s_next.irq = (|(s_next.irq_stat & s_next.irq_mask))
                 | (s_next.sfie & s_next.sf);

    if (s_axi_awvalid && s_reg.awready) begin
      s_next.aw_held = 1'b1;
      s_next.awready = 1'b0;
      s_next.aw_idx = s_axi_awaddr[15:2];
      s_next.aw_hit_ok = aw_hi_ok;
    end
    if (s_axi_wvalid && s_reg.wready) begin
      s_next.w_held = 1'b1;
      s_next.wready = 1'b0;
      s_next.wdata = s_axi_wdata[7:0];
      s_next.wlane = s_axi_wstrb[0];
    end
    if (wr_go) begin
      s_next.aw_held = 1'b0;
      s_next.w_held = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = wr_hit ? `FFS_RESP_OKAY : `FFS_RESP_SLVERR;
    end
    if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
      s_next.awready = 1'b1;
      s_next.wready = 1'b1;
    end

    if (ar_take) begin
      s_next.arready = 1'b0;
      s_next.rvalid = 1'b1;
      s_next.rdata = rd_word;
      s_next.rresp = ar_hit ? `FFS_RESP_OKAY : `FFS_RESP_SLVERR;
    end
    if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
      s_next.arready = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
      s_reg.cmd <= CS_INIT;
      s_reg.cpl_stat <= `FFS_RST_CPL;
      s_reg.sfie <= RST_CFG[`FFS_BIT_SFIE];
      s_reg.ign_sf <= RST_CFG[`FFS_BIT_IGN_SF];
      s_reg.irq_mask <= `FFS_RST_IRQ_MASK;
      s_reg.awready <= 1'b1;
      s_reg.wready <= 1'b1;
      s_reg.arready <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign s_axi_awready = s_reg.awready;
  assign s_axi_wready = s_reg.wready;
  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_arready = s_reg.arready;
  assign s_axi_rvalid = s_reg.rvalid;
  assign s_axi_rdata = s_reg.rdata;
  assign s_axi_rresp = s_reg.rresp;
  assign cmd_launch = s_reg.launch;
  assign rd_data_out = s_reg.rd_data;
  assign rd_data_valid = s_reg.rd_valid;
  assign irq = s_reg.irq;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  busy_read_a: assert property (ar_take && ar_idx == `FFS_IDX_CSTAT
    |=> s_axi_rdata[`FFS_BIT_BUSY] == !s_axi_rdata[`FFS_BIT_CPL])
    else $error("busy bit disagrees with complete flag");

  // Busy sits at bit 3, so only bits 6:4 and 2 are reserved here
  rsvd_zero_a: assert property (ar_take |=> s_axi_rdata[31:8] == 24'h0
    && ($past(ar_idx) != `FFS_IDX_CSTAT
        || (s_axi_rdata[6:4] == 3'h0 && !s_axi_rdata[`FFS_BIT_RSVD]))
    && ($past(ar_idx) != `FFS_IDX_ESTAT || s_axi_rdata[7:2] == 6'h0))
    else $error("reserved bits read nonzero");

  cmd_status_a: assert property (s_reg.cmd == CS_RUN && cmd_done.done
    |=> s_reg.cpl_flag && s_reg.cpl_stat == $past(cmd_done.err) && !ctrl_busy_flag)
    else $error("completion status not captured");

  init_fault_a: assert property (s_reg.cmd == CS_INIT && init_done && init_dfault
    |=> s_reg.cpl_stat[`FFS_CPL_MSB] && s_reg.cpl_flag)
    else $error("reset-sequence double fault not reported");

  df_set_a: assert property (rd.strobe && rd.double_f |=> s_reg.df)
    else $error("double fault flag not set one cycle after read");

  collide_both_a: assert property (rd.strobe && rd.collide |=> s_reg.sf && s_reg.df)
    else $error("collision did not set both flags");

  df_clear_a: assert property (clr_df && !set_df |=> !s_reg.df)
    else $error("double fault flag not cleared");

  parity_excl_a: assert property (!rd.collide |-> !(set_sf && set_df))
    else $error("parity fault reported as both kinds");

  sf_set_a: assert property (rd.strobe && rd.single && !rd.double_f && !s_reg.ign_sf
    |=> s_reg.sf)
    else $error("single fault flag not set");

  fix_data_a: assert property (rd.strobe && rd.single && !rd.double_f && !rd.collide
    |=> rd_data_valid && rd_data_out == ($past(rd.data) ^ (8'h01 << $past(rd.flip_idx))))
    else $error("single-bit fault not corrected");

  sf_clear_a: assert property (clr_sf && !set_sf |=> !s_reg.sf)
    else $error("single fault flag not cleared");

  sf_keep_a: assert property (wr_estat && !s_reg.wdata[`FFS_BIT_SF] && s_reg.sf
    |=> s_reg.sf)
    else $error("writing zero changed single fault flag");

  sf_irq_a: assert property (s_reg.sfie && s_reg.sf |-> irq)
    else $error("single fault interrupt missing");

  launch_a: assert property (cmd_go |=> !s_reg.cpl_flag && cmd_launch ##1 !cmd_launch)
    else $error("command launch not taken");

  run_low_a: assert property (s_reg.cmd == CS_RUN && !cmd_done.done |=> !s_reg.cpl_flag)
    else $error("complete flag rose before completion");

  set_wins_a: assert property (set_sf && clr_sf |=> s_reg.sf)
    else $error("clear beat a simultaneous fault");

  ign_sf_a: assert property (rd.strobe && rd.single && !rd.double_f && !rd.collide
    && s_reg.ign_sf && !s_reg.sf |=> !s_reg.sf)
    else $error("ignored single fault still flagged");

  cmd_cycle_c: cover property (cmd_go ##[1:20] (s_reg.cmd == CS_RUN && cmd_done.done));
  collide_c: cover property (rd.strobe && rd.collide);
  sf_irq_c: cover property (s_reg.sfie && set_sf ##1 irq);
  set_clear_c: cover property (set_df && clr_df);

endmodule

`default_nettype wire

// ==== ffs_map.svh ====
`ifndef FFS_MAP_SVH
`define FFS_MAP_SVH

// Register word indices; byte address is four times the index
`define FFS_IDX_CFG 14'h3024
`define FFS_IDX_CSTAT 14'h3026
`define FFS_IDX_ESTAT 14'h3027
`define FFS_IDX_IRQ_STAT 14'h3030
`define FFS_IDX_IRQ_MASK 14'h3031

// Command status register fields
`define FFS_BIT_CPL 7
`define FFS_BIT_BUSY 3
`define FFS_BIT_RSVD 2
`define FFS_CPL_MSB 1
`define FFS_CPL_DFAULT 2'h2

// Error status register fields
`define FFS_BIT_DF 1
`define FFS_BIT_SF 0

// Configuration register fields
`define FFS_BIT_SFIE 0
`define FFS_BIT_IGN_SF 4

// Interrupt status / mask layout
`define FFS_IRQ_SF 0
`define FFS_IRQ_DF 1
`define FFS_IRQ_CMD 2
`define FFS_IRQ_W 3

// Reset values
`define FFS_RST_CFG 8'h00
`define FFS_RST_IRQ_MASK 3'h0
`define FFS_RST_CPL 2'h0

// Bus responses
`define FFS_RESP_OKAY 2'h0
`define FFS_RESP_SLVERR 2'h2

`endif

// ==== ffs_pkg.sv ====
`default_nettype none

package ffs_pkg;

  typedef enum logic [2:0] {
    CS_INIT = 3'b001,
    CS_IDLE = 3'b010,
    CS_RUN = 3'b100
  } ffs_cmd_e;

  typedef logic [7:0] ffs_byte_t;

  typedef struct packed {
    logic strobe;
    logic single;
    logic double_f;
    logic collide;
    ffs_byte_t data;
    logic [2:0] flip_idx;
  } ffs_rd_s;

  typedef struct packed {
    logic done;
    logic [1:0] err;
  } ffs_cmd_done_s;

  typedef struct packed {
    ffs_cmd_e cmd;
    logic cpl_flag;
    logic [1:0] cpl_stat;
    logic sf;
    logic df;
    logic sfie;
    logic ign_sf;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic irq;
    logic launch;
    ffs_byte_t rd_data;
    logic rd_valid;
    logic awready;
    logic wready;
    logic aw_held;
    logic w_held;
    logic aw_hit_ok;
    logic [13:0] aw_idx;
    ffs_byte_t wdata;
    logic wlane;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ffs_state_s;

endpackage

`default_nettype wire

// ==== ffs_fault_sort.sv ====
`timescale 1ns/1ps
`default_nettype none

module ffs_fault_sort
  import ffs_pkg::*;
(
  input wire ffs_rd_s rd,
  input wire logic ignore_single_fault,
  output logic set_sf,
  output logic set_df,
  output ffs_byte_t data_fixed
);

  logic parity_single;
  logic parity_double;

  // Double outranks single so a parity fault is never reported as both
  assign parity_double = rd.strobe & rd.double_f & ~rd.collide;
  assign parity_single = rd.strobe & rd.single & ~rd.double_f & ~rd.collide;

  assign set_df = parity_double | (rd.strobe & rd.collide);
  assign set_sf = (parity_single & ~ignore_single_fault) | (rd.strobe & rd.collide);

  // Correction happens regardless of whether the flag is recorded
  assign data_fixed = parity_single ? (rd.data ^ (8'h01 << rd.flip_idx)) : rd.data;

endmodule

`default_nettype wire

// ==== ffs_top_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ffs_map.svh"

module ffs_top_tb_top
  import ffs_pkg::*;
;
  localparam logic [15:0] A_CFG = {`FFS_IDX_CFG, 2'b00};
  localparam logic [15:0] A_CMD = {`FFS_IDX_CSTAT, 2'b00};
  localparam logic [15:0] A_ERR = {`FFS_IDX_ESTAT, 2'b00};
  localparam logic [15:0] A_IST = {`FFS_IDX_IRQ_STAT, 2'b00};
  localparam logic [15:0] A_IMSK = {`FFS_IDX_IRQ_MASK, 2'b00};
  localparam logic [15:0] A_BAD = 16'h0ffc;

  logic aclk, aresetn;
  logic [15:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic init_done, init_dfault, cmd_launch, rd_data_valid, irq;
  ffs_cmd_done_s cmd_done;
  ffs_rd_s rd;
  ffs_byte_t rd_data_out;
  int errors, num_checks;
  int launches = 0;

  ffs_top #(.ADDR_W(16)) ffs_top_i (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .init_done(init_done), .init_dfault(init_dfault),
    .cmd_done(cmd_done), .cmd_launch(cmd_launch), .rd(rd),
    .rd_data_out(rd_data_out), .rd_data_valid(rd_data_valid), .irq(irq)
  );

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    if (cmd_launch === 1'b1) launches <= launches + 1;
  end

  task automatic stop_test();
    if (errors == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic settle();
    @(posedge aclk);
    #1;
  endtask

  // Valids and bready raised together; each released at its own handshake
  task automatic wr(input logic [15:0] a, input logic [7:0] d, output logic [1:0] resp);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    resp = bresp;
    bready <= 1'b0;
    if (n == 50) begin
      errors++;
      stop_test();
    end
  endtask

  task automatic rdreg(input logic [15:0] a, output logic [31:0] d, output logic [1:0] resp);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
    if (n == 50) begin
      errors++;
      stop_test();
    end
  endtask

  task automatic wr_ok(input logic [15:0] a, input logic [7:0] d);
    logic [1:0] r;
    wr(a, d, r);
    check(r, `FFS_RESP_OKAY);
  endtask

  task automatic expect_reg(input logic [15:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    rdreg(a, d, r);
    check(r, `FFS_RESP_OKAY);
    check(d, exp);
  endtask

  // One-cycle array read strobe; corrected data and valid pulse a cycle later
  task automatic array_read(input logic s, input logic dbl, input logic c,
                            input logic [7:0] dat, input logic [2:0] f, input logic [7:0] exp);
    @(posedge aclk);
    rd <= '{1'b1, s, dbl, c, dat, f};
    @(posedge aclk);
    rd <= '0;
    #1;
    check(rd_data_valid, 1'b1);
    check(rd_data_out, exp);
    settle();
    check(rd_data_valid, 1'b0);
  endtask

  // Second reset in mid-run, this time with a clean reset sequence
  task automatic t_rerun_reset();
    @(posedge aclk);
    aresetn <= 1'b0;
    init_done <= 1'b0;
    init_dfault <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    expect_reg(A_CMD, 32'h08);
    expect_reg(A_ERR, 32'h0);
    @(posedge aclk);
    init_done <= 1'b1;
    settle();
    expect_reg(A_CMD, 32'h80);
  endtask

  task automatic t_reset_seq();
    expect_reg(A_CMD, 32'h08);
    expect_reg(A_ERR, 32'h0);
    expect_reg(A_CFG, 32'h0);
    expect_reg(A_IMSK, 32'h0);
    @(posedge aclk);
    init_done <= 1'b1;
    init_dfault <= 1'b1;
    settle();
    expect_reg(A_CMD, 32'h82);
  endtask

  task automatic t_command();
    wr_ok(A_CMD, 8'h84);
    settle();
    check(launches, 1);
    expect_reg(A_CMD, 32'h08);
    wr_ok(A_CMD, 8'h80);
    settle();
    check(launches, 1);
    @(posedge aclk);
    cmd_done <= '{1'b1, 2'h1};
    @(posedge aclk);
    cmd_done <= '0;
    expect_reg(A_CMD, 32'h81);
    expect_reg(A_IST, 32'h4);
    wr_ok(A_IMSK, 8'h4);
    settle();
    check(irq, 1'b1);
    wr_ok(A_IST, 8'h4);
    settle();
    check(irq, 1'b0);
  endtask

  task automatic t_single();
    wr_ok(A_CFG, 8'h01);
    array_read(1'b1, 1'b0, 1'b0, 8'h5a, 3'd2, 8'h5e);
    check(irq, 1'b1);
    expect_reg(A_ERR, 32'h1);
    wr_ok(A_ERR, 8'h00);
    wr_ok(A_ERR, 8'h02);
    expect_reg(A_ERR, 32'h1);
    wr_ok(A_ERR, 8'h01);
    settle();
    check(irq, 1'b0);
    expect_reg(A_ERR, 32'h0);
  endtask

  task automatic t_double_collide();
    array_read(1'b0, 1'b1, 1'b0, 8'hc3, 3'd0, 8'hc3);
    expect_reg(A_ERR, 32'h2);
    wr_ok(A_ERR, 8'h00);
    expect_reg(A_ERR, 32'h2);
    wr_ok(A_ERR, 8'hff);
    expect_reg(A_ERR, 32'h0);
    array_read(1'b1, 1'b1, 1'b0, 8'h11, 3'd0, 8'h11);
    expect_reg(A_ERR, 32'h2);
    wr_ok(A_ERR, 8'h02);
    array_read(1'b0, 1'b0, 1'b1, 8'h22, 3'd0, 8'h22);
    expect_reg(A_ERR, 32'h3);
    wr_ok(A_ERR, 8'h03);
    wr_ok(A_CFG, 8'h10);
    array_read(1'b1, 1'b0, 1'b0, 8'h00, 3'd7, 8'h80);
    expect_reg(A_ERR, 32'h0);
    wr_ok(A_CFG, 8'h00);
  endtask

  // Clear write lands at the edge after both channels are taken; strobe hits that edge
  task automatic t_set_beats_clear();
    array_read(1'b1, 1'b0, 1'b0, 8'h01, 3'd0, 8'h00);
    fork
      wr_ok(A_ERR, 8'h01);
      begin
        @(posedge aclk);
        @(posedge aclk);
        rd <= '{1'b1, 1'b1, 1'b0, 1'b0, 8'h01, 3'd0};
        @(posedge aclk);
        rd <= '0;
      end
    join
    expect_reg(A_ERR, 32'h1);
    wr_ok(A_ERR, 8'h01);
  endtask

  task automatic t_unmapped();
    logic [31:0] d;
    logic [1:0] r;
    wr(A_BAD, 8'hff, r);
    check(r, `FFS_RESP_SLVERR);
    rdreg(A_BAD, d, r);
    check(r, `FFS_RESP_SLVERR);
    check(d, 32'h0);
  endtask

  initial begin
    errors = 0;
    num_checks = 0;
    aresetn = 1'b0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = '0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    init_done = 1'b0;
    init_dfault = 1'b0;
    cmd_done = '0;
    rd = '0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset_seq();
    t_command();
    t_single();
    t_double_collide();
    t_set_beats_clear();
    t_unmapped();
    t_rerun_reset();
    stop_test();
  end
endmodule

`default_nettype wire
